// >>> hdl/dps_life_counter.sv
/*
  dps_life_counter: slave sign-of-life counter and master sign-of-life
  monitor, one step per cyclic exchange.
  assumes exchange_i is a one-cycle pulse from logic on sys_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module dps_life_counter
  import dps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic exchange_i,
  input wire logic [dps_pkg::LIFE_W-1:0] master_life_i,
  output logic [dps_pkg::LIFE_W-1:0] slave_life_o,
  output logic [dps_pkg::LIFE_W-1:0] master_life_o,
  output logic master_life_fault_o
);

  typedef struct packed {
    logic [LIFE_W-1:0] slave;
    logic [LIFE_W-1:0] master;
    logic seen;
    logic fault;
  } dps_life_state_t;

  dps_life_state_t state_reg;
  dps_life_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    if (exchange_i)
    begin
      state_next.slave = state_reg.slave + LIFE_STEP;
      state_next.master = master_life_i;
      state_next.seen = 1'b1;
      // first exchange has no previous value to compare against
      state_next.fault = state_reg.seen && (master_life_i != state_reg.master + LIFE_STEP);
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= '{slave: RST_LIFE, master: RST_LIFE, seen: 1'b0, fault: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign slave_life_o = state_reg.slave;
  assign master_life_o = state_reg.master;
  assign master_life_fault_o = state_reg.fault;

endmodule

`default_nettype wire

// >>> hdl/dps_positioning_words.sv
/*
  dps_positioning_words: decodes the cyclic positioning control words of a
  servo drive and assembles its two main status words.
  assumes all inputs come from logic on sys_clk_i; exchange_i pulses one
  cycle when a fresh telegram is valid on the word inputs.
*/
// Function
// - mode word bit 0 absolute, else relative
// - mode word bits 1-2 move direction
// - aux bit 0 switches tracking mode
// - tracking loads setpoint with actual position
// - aux bit 1 sets reference, bit 2 cam
// - aux bit 5 incremental, else velocity jog
// - word a bits 0-5 block number
// - word a bit 8 absolute, bits 9-10 direction
// - bit 12 continuous, else activate edge change
// - word a bit 14 setting-up, else positioning
// - word b bit 9 negative reference search
// - word b bits 14-15 limits, stop cam
// - status bits 0-2 readiness and enable
// - status bits 4-6 stops inactive, inhibit
// - status bits 8-10 tolerance, control, comparison
// - status bit 11 low at limit
// - status bits 12, 13, 15 brake, thermal
// - status bit 14 speed not negative
// - second word alarm class, endstop, pulses
// - second word bits 12-15 slave life
`timescale 1ns/1ns
`default_nettype none

module dps_positioning_words
  import dps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic exchange_i,
  input wire logic [dps_pkg::WORD_W-1:0] direct_setpoint_mode_word_i,
  input wire logic [dps_pkg::WORD_W-1:0] position_aux_control_word_i,
  input wire logic [dps_pkg::WORD_W-1:0] positioning_control_word_a_i,
  input wire logic [dps_pkg::WORD_W-1:0] positioning_control_word_b_i,
  input wire logic [dps_pkg::WORD_W-1:0] main_drive_control_word_i,
  input wire logic [dps_pkg::WORD_W-1:0] second_drive_control_word_i,
  input wire logic [dps_pkg::POS_W-1:0] target_position_i,
  input wire logic [dps_pkg::POS_W-1:0] actual_position_i,
  input wire logic ready_servo_on_i,
  input wire logic ready_operation_i,
  input wire logic operation_enabled_i,
  input wire logic fault_i,
  input wire logic coast_stop_command_i,
  input wire logic quick_stop_command_i,
  input wire logic switch_on_inhibit_i,
  input wire logic alarm_i,
  input wire logic speed_in_tolerance_i,
  input wire logic control_requested_i,
  input wire logic speed_compare_reached_i,
  input wire logic torque_limit_reached_i,
  input wire logic brake_open_i,
  input wire logic motor_overtemp_alarm_i,
  input wire logic power_unit_overload_alarm_i,
  input wire logic [dps_pkg::POS_W-1:0] actual_speed_i,
  input wire logic [1:0] alarm_class_i,
  input wire logic fixed_endstop_i,
  input wire logic pulses_enabled_i,
  output logic direct_absolute_o,
  output dps_pkg::dps_dir_t direct_direction_o,
  output logic tracking_o,
  output logic set_reference_o,
  output logic reference_cam_o,
  output logic incremental_jog_o,
  output logic [dps_pkg::BLOCK_W-1:0] block_number_o,
  output logic block_absolute_o,
  output dps_pkg::dps_dir_t block_direction_o,
  output logic continuous_transfer_o,
  output logic setting_up_o,
  output logic direct_setpoint_entry_o,
  output logic reference_search_negative_o,
  output logic sw_limit_enable_o,
  output logic stop_cam_o,
  output logic [dps_pkg::POS_W-1:0] position_setpoint_o,
  output logic block_change_o,
  output dps_pkg::dps_sp_mode_t setpoint_mode_o,
  output logic [dps_pkg::WORD_W-1:0] main_drive_status_word_o,
  output logic [dps_pkg::WORD_W-1:0] second_drive_status_word_o,
  output logic [dps_pkg::LIFE_W-1:0] master_sign_of_life_o,
  output logic master_life_fault_o
);

  typedef struct packed {
    logic direct_absolute;
    dps_dir_t direct_direction;
    logic tracking;
    logic set_reference;
    logic reference_cam;
    logic incremental_jog;
    logic [BLOCK_W-1:0] block_number;
    logic block_absolute;
    dps_dir_t block_direction;
    logic continuous;
    logic setting_up;
    logic entry;
    logic ref_negative;
    logic sw_limit;
    logic stop_cam;
    logic activate_prev;
    logic block_change;
    dps_sp_mode_t sp_mode;
    logic [POS_W-1:0] setpoint;
    logic [WORD_W-1:0] main_status;
    logic [WORD_W-1:0] second_status;
  } dps_state_t;

  dps_state_t state_reg;
  dps_state_t state_next;
  logic [LIFE_W-1:0] slave_life;
  logic activate_now;
  logic activate_rise;

  // 0 and 3 both mean shortest path, so the enum never holds 3
  function automatic dps_dir_t dir_decode(input logic [1:0] code);
    dps_dir_t dir;
    case (code)
      2'h1: dir = DPS_DIR_POSITIVE;
      2'h2: dir = DPS_DIR_NEGATIVE;
      default: dir = DPS_DIR_SHORTEST;
    endcase
    return dir;
  endfunction

  dps_life_counter dps_life_counter_i (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .exchange_i(exchange_i),
    .master_life_i(second_drive_control_word_i[SCW_LIFE_LSB +: LIFE_W]),
    .slave_life_o(slave_life),
    .master_life_o(master_sign_of_life_o),
    .master_life_fault_o(master_life_fault_o)
  );

  assign activate_now = main_drive_control_word_i[MCW_ACTIVATE_BIT];
  assign activate_rise = activate_now && !state_reg.activate_prev;

  always_comb
  begin
    state_next = state_reg;
    state_next.block_change = 1'b0;
    if (exchange_i)
    begin
      // reserved bits of every control word are never looked at
      state_next.direct_absolute = direct_setpoint_mode_word_i[MODE_ABS_BIT];
      state_next.direct_direction =
        dir_decode(direct_setpoint_mode_word_i[MODE_DIR_LSB +: 2]);
      // either auxiliary word can switch on the shared functions
      state_next.tracking = position_aux_control_word_i[AUX_TRACK_BIT] ||
        positioning_control_word_b_i[AUX_TRACK_BIT];
      state_next.set_reference = position_aux_control_word_i[AUX_SETREF_BIT] ||
        positioning_control_word_b_i[AUX_SETREF_BIT];
      state_next.reference_cam = position_aux_control_word_i[AUX_REFCAM_BIT] ||
        positioning_control_word_b_i[AUX_REFCAM_BIT];
      state_next.incremental_jog = position_aux_control_word_i[AUX_INCJOG_BIT] ||
        positioning_control_word_b_i[AUX_INCJOG_BIT];
      state_next.block_number =
        positioning_control_word_a_i[PCA_BLOCK_LSB +: BLOCK_W];
      state_next.block_absolute = positioning_control_word_a_i[PCA_ABS_BIT];
      state_next.block_direction =
        dir_decode(positioning_control_word_a_i[PCA_DIR_LSB +: 2]);
      state_next.continuous = positioning_control_word_a_i[PCA_CONT_BIT];
      state_next.setting_up = positioning_control_word_a_i[PCA_SETUP_BIT];
      state_next.entry = positioning_control_word_a_i[PCA_ENTRY_BIT];
      state_next.ref_negative = positioning_control_word_b_i[PCB_REFNEG_BIT];
      state_next.sw_limit = positioning_control_word_b_i[PCB_SWLIM_BIT];
      state_next.stop_cam = positioning_control_word_b_i[PCB_STOPCAM_BIT];
      state_next.activate_prev = activate_now;

      // setpoint source for the coming cycle
      if (state_next.tracking)
      begin
        state_next.sp_mode = DPS_SP_TRACK;
      end
      else if (state_next.entry && state_next.continuous)
      begin
        state_next.sp_mode = DPS_SP_FOLLOW;
      end
      else
      begin
        state_next.sp_mode = DPS_SP_HOLD;
      end

      // block change: every exchange when continuous, else only on trigger edge
      if (!state_next.tracking && state_next.entry)
      begin
        if (state_next.continuous || activate_rise)
        begin
          state_next.setpoint = target_position_i;
          state_next.block_change = 1'b1;
        end
      end

      state_next.main_status = RST_WORD;
      state_next.main_status[0] = ready_servo_on_i;
      state_next.main_status[1] = ready_operation_i;
      state_next.main_status[2] = operation_enabled_i;
      state_next.main_status[3] = fault_i;
      state_next.main_status[4] = !coast_stop_command_i;
      state_next.main_status[5] = !quick_stop_command_i;
      state_next.main_status[6] = switch_on_inhibit_i;
      state_next.main_status[7] = alarm_i;
      state_next.main_status[8] = speed_in_tolerance_i;
      state_next.main_status[9] = control_requested_i;
      state_next.main_status[10] = speed_compare_reached_i;
      state_next.main_status[11] = !torque_limit_reached_i;
      state_next.main_status[12] = brake_open_i;
      state_next.main_status[13] = !motor_overtemp_alarm_i;
      state_next.main_status[14] = !actual_speed_i[POS_W-1];
      state_next.main_status[15] = !power_unit_overload_alarm_i;

      // unused positions stay zero from the clear below
      state_next.second_status = RST_WORD;
      state_next.second_status[SSW_CLASS_LSB +: 2] = alarm_class_i;
      state_next.second_status[SSW_ENDSTOP_BIT] = fixed_endstop_i;
      state_next.second_status[SSW_PULSE_BIT] = pulses_enabled_i;
      // counter value before this exchange's step
      state_next.second_status[SSW_LIFE_LSB +: LIFE_W] = slave_life;
    end

    // tracking follows every clock, not just each exchange, so the
    // setpoint never lags the measured position by a whole bus cycle
    if (state_reg.tracking && !(exchange_i && !state_next.tracking))
    begin
      state_next.setpoint = actual_position_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= '{
        direct_absolute: 1'b0,
        direct_direction: DPS_DIR_SHORTEST,
        tracking: 1'b0,
        set_reference: 1'b0,
        reference_cam: 1'b0,
        incremental_jog: 1'b0,
        block_number: '0,
        block_absolute: 1'b0,
        block_direction: DPS_DIR_SHORTEST,
        continuous: 1'b0,
        setting_up: 1'b0,
        entry: 1'b0,
        ref_negative: 1'b0,
        sw_limit: 1'b0,
        stop_cam: 1'b0,
        activate_prev: 1'b0,
        block_change: 1'b0,
        sp_mode: DPS_SP_HOLD,
        setpoint: RST_POS,
        main_status: RST_WORD,
        second_status: RST_WORD
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign direct_absolute_o = state_reg.direct_absolute;
  assign direct_direction_o = state_reg.direct_direction;
  assign tracking_o = state_reg.tracking;
  assign set_reference_o = state_reg.set_reference;
  assign reference_cam_o = state_reg.reference_cam;
  assign incremental_jog_o = state_reg.incremental_jog;
  assign block_number_o = state_reg.block_number;
  assign block_absolute_o = state_reg.block_absolute;
  assign block_direction_o = state_reg.block_direction;
  assign continuous_transfer_o = state_reg.continuous;
  assign setting_up_o = state_reg.setting_up;
  assign direct_setpoint_entry_o = state_reg.entry;
  assign reference_search_negative_o = state_reg.ref_negative;
  assign sw_limit_enable_o = state_reg.sw_limit;
  assign stop_cam_o = state_reg.stop_cam;
  assign position_setpoint_o = state_reg.setpoint;
  assign block_change_o = state_reg.block_change;
  assign setpoint_mode_o = state_reg.sp_mode;
  assign main_drive_status_word_o = state_reg.main_status;
  assign second_drive_status_word_o = state_reg.second_status;

endmodule

`default_nettype wire

// >>> shared/dps_pkg.sv
/*
  dps_pkg: field positions, reset values and types shared by the drive
  positioning control/status word block and its sign-of-life counter.
  assumes 16-bit process-data words exchanged once per fieldbus cycle.
*/
`default_nettype none

package dps_pkg;

  localparam int WORD_W = 16;
  localparam int POS_W = 32;
  localparam int LIFE_W = 4;
  localparam int BLOCK_W = 6;

  // direct-setpoint mode word
  localparam int MODE_ABS_BIT = 0;
  localparam int MODE_DIR_LSB = 1;

  // positioning auxiliary control word and second positioning control word
  localparam int AUX_TRACK_BIT = 0;
  localparam int AUX_SETREF_BIT = 1;
  localparam int AUX_REFCAM_BIT = 2;
  localparam int AUX_INCJOG_BIT = 5;

  // first positioning control word
  localparam int PCA_BLOCK_LSB = 0;
  localparam int PCA_ABS_BIT = 8;
  localparam int PCA_DIR_LSB = 9;
  localparam int PCA_CONT_BIT = 12;
  localparam int PCA_SETUP_BIT = 14;
  localparam int PCA_ENTRY_BIT = 15;

  // second positioning control word
  localparam int PCB_REFNEG_BIT = 9;
  localparam int PCB_SWLIM_BIT = 14;
  localparam int PCB_STOPCAM_BIT = 15;

  // main and second drive control words
  localparam int MCW_ACTIVATE_BIT = 6;
  localparam int SCW_LIFE_LSB = 12;

  // second drive status word
  localparam int SSW_CLASS_LSB = 5;
  localparam int SSW_ENDSTOP_BIT = 8;
  localparam int SSW_PULSE_BIT = 10;
  localparam int SSW_LIFE_LSB = 12;

  // reset values and sign-of-life step
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [POS_W-1:0] RST_POS = 32'h0000_0000;
  localparam logic [LIFE_W-1:0] RST_LIFE = 4'h0;
  localparam logic [LIFE_W-1:0] LIFE_STEP = 4'h1;

  typedef enum logic [1:0] {
    DPS_DIR_SHORTEST = 2'h0,
    DPS_DIR_POSITIVE = 2'h1,
    DPS_DIR_NEGATIVE = 2'h2
  } dps_dir_t;

  typedef enum logic [2:0] {
    DPS_SP_HOLD = 3'h1,
    DPS_SP_TRACK = 3'h2,
    DPS_SP_FOLLOW = 3'h4
  } dps_sp_mode_t;

endpackage

`default_nettype wire

// >>> testbench/dps_plc_model.sv
/*
  dps_plc_model: controller side of the cyclic exchange, issues the exchange
  strobe and the master sign-of-life. assumes send_i changes after the edge.
*/
`timescale 1ns/1ns
`default_nettype none

module dps_plc_model
  import dps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic send_i,
  input wire logic skip_i,
  output logic exchange_o,
  output logic [dps_pkg::WORD_W-1:0] second_drive_control_word_o
);
  logic [LIFE_W-1:0] life_reg;

  assign exchange_o = send_i;
  // reserved bits held low so only the life field can matter
  assign second_drive_control_word_o = {life_reg, 12'h000};

  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      life_reg <= 4'h0;
    else if (send_i)
      // skip_i breaks the count once so the drive's life check can trip
      life_reg <= life_reg + (skip_i ? 4'h2 : 4'h1);
endmodule

`default_nettype wire

// >>> testbench/dps_positioning_words_assertions.sv
/*
  dps_pw_checker: concurrent checks on the positioning word block ports.
  assumes one clock domain and binding onto dps_positioning_words by name.
*/
`timescale 1ns/1ns
`default_nettype none

module dps_pw_checker
  import dps_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic exchange_i,
  input wire logic [dps_pkg::WORD_W-1:0] direct_setpoint_mode_word_i,
  input wire logic [dps_pkg::WORD_W-1:0] positioning_control_word_a_i,
  input wire logic [dps_pkg::WORD_W-1:0] main_drive_control_word_i,
  input wire logic [dps_pkg::POS_W-1:0] target_position_i,
  input wire logic [dps_pkg::POS_W-1:0] actual_position_i,
  input wire logic torque_limit_reached_i,
  input wire logic [dps_pkg::POS_W-1:0] actual_speed_i,
  input wire logic [1:0] alarm_class_i,
  input wire logic fixed_endstop_i,
  input wire logic pulses_enabled_i,
  input wire logic direct_absolute_o,
  input wire dps_pkg::dps_dir_t direct_direction_o,
  input wire logic tracking_o,
  input wire logic [dps_pkg::BLOCK_W-1:0] block_number_o,
  input wire logic [dps_pkg::POS_W-1:0] position_setpoint_o,
  input wire logic block_change_o,
  input wire logic [dps_pkg::WORD_W-1:0] main_drive_status_word_o,
  input wire logic [dps_pkg::WORD_W-1:0] second_drive_status_word_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic act_seen;

  // activate bit as taken at the previous exchange, the reference for the edge
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      act_seen <= 1'b0;
    else if (exchange_i)
      act_seen <= main_drive_control_word_i[MCW_ACTIVATE_BIT];
  end

  AST_ABS: assert property (exchange_i |=>
    direct_absolute_o == $past(direct_setpoint_mode_word_i[0])) else $error("absolute flag");
  AST_DIR: assert property (exchange_i |=> direct_direction_o ==
    ((&$past(direct_setpoint_mode_word_i[2:1])) ? 2'h0 : $past(direct_setpoint_mode_word_i[2:1])))
    else $error("mode word direction");
  AST_BLK: assert property (exchange_i |=>
    block_number_o == $past(positioning_control_word_a_i[5:0])) else $error("block number");
  // both cycles tracking: the exchange that starts tracking does not load the setpoint
  AST_TRK: assert property (tracking_o && $past(tracking_o) |->
    position_setpoint_o == $past(actual_position_i)) else $error("tracking setpoint");
  AST_LIM: assert property (exchange_i |=>
    main_drive_status_word_o[11] == !$past(torque_limit_reached_i)) else $error("limit bit");
  AST_SPD: assert property (exchange_i |=>
    main_drive_status_word_o[14] == !$past(actual_speed_i[31])) else $error("speed sign bit");
  AST_ST2: assert property (exchange_i |=> second_drive_status_word_o[11:0] == {1'b0,
    $past(pulses_enabled_i), 1'b0, $past(fixed_endstop_i), 1'b0, $past(alarm_class_i), 5'h00})
    else $error("second status word");
  AST_LIFE: assert property (exchange_i ##1 exchange_i |=>
    second_drive_status_word_o[15:12] == $past(second_drive_status_word_o[15:12]) + 4'h1)
    else $error("slave life step");
  AST_CHG: assert property (block_change_o |-> $past(exchange_i) &&
    $past(positioning_control_word_a_i[15]) && position_setpoint_o == $past(target_position_i))
    else $error("block change load");
  AST_EDGE: assert property (block_change_o && !$past(positioning_control_word_a_i[12]) |->
    $past(main_drive_control_word_i[6]) && !$past(act_seen))
    else $error("block change trigger");
endmodule

`default_nettype wire

// >>> testbench/dps_positioning_words_tb_top.sv
/*
  dps_positioning_words_tb_top: directed bench for the positioning word block.
  assumes the controller model and the checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

module dps_positioning_words_tb_top;
  import dps_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic send = 1'b0;
  logic skip = 1'b0;
  logic exchange_i;
  logic [15:0] direct_setpoint_mode_word_i, position_aux_control_word_i;
  logic [15:0] positioning_control_word_a_i, positioning_control_word_b_i;
  logic [15:0] main_drive_control_word_i, second_drive_control_word_i;
  logic [31:0] target_position_i, actual_position_i, actual_speed_i;
  logic [1:0] alarm_class_i;
  logic [16:0] st;
  logic ready_servo_on_i, ready_operation_i, operation_enabled_i, fault_i;
  logic coast_stop_command_i, quick_stop_command_i, switch_on_inhibit_i, alarm_i;
  logic speed_in_tolerance_i, control_requested_i, speed_compare_reached_i;
  logic torque_limit_reached_i, brake_open_i, motor_overtemp_alarm_i;
  logic power_unit_overload_alarm_i, fixed_endstop_i, pulses_enabled_i;
  logic direct_absolute_o, tracking_o, set_reference_o, reference_cam_o;
  logic incremental_jog_o, block_absolute_o, continuous_transfer_o, setting_up_o;
  logic direct_setpoint_entry_o, reference_search_negative_o, sw_limit_enable_o;
  logic stop_cam_o, block_change_o, master_life_fault_o;
  dps_dir_t direct_direction_o, block_direction_o;
  dps_sp_mode_t setpoint_mode_o;
  logic [5:0] block_number_o;
  logic [31:0] position_setpoint_o;
  logic [15:0] main_drive_status_word_o, second_drive_status_word_o;
  logic [3:0] master_sign_of_life_o, nx;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  assign {pulses_enabled_i, fixed_endstop_i, power_unit_overload_alarm_i, motor_overtemp_alarm_i,
    brake_open_i, torque_limit_reached_i, speed_compare_reached_i, control_requested_i,
    speed_in_tolerance_i, alarm_i, switch_on_inhibit_i, quick_stop_command_i,
    coast_stop_command_i, fault_i, operation_enabled_i, ready_operation_i, ready_servo_on_i} = st;

  dps_positioning_words dps_positioning_words_i (.*);
  dps_plc_model dps_plc_model_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .send_i(send),
    .skip_i(skip), .exchange_o(exchange_i),
    .second_drive_control_word_o(second_drive_control_word_i));

  always #5 sys_clk_i = ~sys_clk_i;

  // generous ceiling: the directed run needs about a hundred cycles
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_life();
    `CHK("slave_life", nx, second_drive_status_word_o[15:12]);
    `CHK("master_life", nx, master_sign_of_life_o);
    `CHK("life_fault", 1'b0, master_life_fault_o);
    nx++;
  endtask

  task automatic xc();
    @(posedge sys_clk_i);
    #1 send = 1'b1;
    @(posedge sys_clk_i);
    #1 send = 1'b0;
    chk_life();
  endtask

  initial
  begin
    {direct_setpoint_mode_word_i, position_aux_control_word_i, main_drive_control_word_i} = '0;
    {positioning_control_word_a_i, positioning_control_word_b_i, target_position_i} = '0;
    {actual_position_i, actual_speed_i, alarm_class_i, st, nx} = '0;
    repeat (8) @(posedge sys_clk_i);
    #1 nrst_i = 1'b1;
    `CHK("rst_mode", DPS_SP_HOLD, setpoint_mode_o);
    `CHK("rst_status", 16'h0000, main_drive_status_word_o);
    // reserved bits are all set here to show they are ignored
    for (int d = 0; d < 4; d++)
    begin
      direct_setpoint_mode_word_i = 16'hfff8 | 16'(d << 1) | 16'(d & 1);
      positioning_control_word_a_i = {1'b0, d[1], 2'b10, 1'b1, d[1:0], ~d[0], 2'b11, 6'(d * 21)};
      xc();
      `CHK("dabs", d[0], direct_absolute_o);
      `CHK("ddir", (d == 3) ? 2'h0 : d[1:0], direct_direction_o);
      `CHK("blk", 6'(d * 21), block_number_o);
      `CHK("babs", ~d[0], block_absolute_o);
      `CHK("bdir", (d == 3) ? 2'h0 : d[1:0], block_direction_o);
      `CHK("setup", d[1], setting_up_o);
      `CHK("entry", 1'b0, direct_setpoint_entry_o);
    end
    $display("done directions");
    for (int k = 0; k < 3; k++)
    begin
      position_aux_control_word_i = (k == 0) ? 16'h0026 : (k == 1) ? 16'h0000 : 16'hffd8;
      positioning_control_word_b_i = (k == 0) ? 16'h4200 : (k == 1) ? 16'h8026 : 16'h3dd8;
      xc();
      `CHK("setref", k < 2, set_reference_o);
      `CHK("refcam", k < 2, reference_cam_o);
      `CHK("incjog", k < 2, incremental_jog_o);
      `CHK("refneg", k == 0, reference_search_negative_o);
      `CHK("swlim", k == 0, sw_limit_enable_o);
      `CHK("stopcam", k == 1, stop_cam_o);
    end
    $display("done aux bits");
    positioning_control_word_a_i = 16'h8000;
    target_position_i = 32'h1234_5678;
    xc();
    `CHK("no_edge", 1'b0, block_change_o);
    main_drive_control_word_i = 16'h0040;
    xc();
    `CHK("edge_chg", 1'b1, block_change_o);
    `CHK("edge_sp", 32'h1234_5678, position_setpoint_o);
    `CHK("edge_mode", DPS_SP_HOLD, setpoint_mode_o);
    target_position_i = 32'h0bad_cafe;
    @(posedge sys_clk_i);
    #1 `CHK("pulse", 1'b0, block_change_o);
    xc();
    `CHK("held_hi", 1'b0, block_change_o);
    `CHK("held_sp", 32'h1234_5678, position_setpoint_o);
    positioning_control_word_a_i = 16'h9000;
    xc();
    `CHK("cont_chg", 1'b1, block_change_o);
    `CHK("cont_sp", 32'h0bad_cafe, position_setpoint_o);
    `CHK("cont_mode", DPS_SP_FOLLOW, setpoint_mode_o);
    $display("done block change");
    position_aux_control_word_i = 16'h0001;
    xc();
    `CHK("track", 1'b1, tracking_o);
    `CHK("track_mode", DPS_SP_TRACK, setpoint_mode_o);
    `CHK("track_chg", 1'b0, block_change_o);
    for (int j = 1; j < 4; j++)
    begin
      actual_position_i = 32'h0001_0000 * j + 32'h0000_0007;
      @(posedge sys_clk_i);
      #1 `CHK("follow", 32'h0001_0000 * j + 32'h0000_0007, position_setpoint_o);
    end
    {position_aux_control_word_i, positioning_control_word_a_i} = '0;
    xc();
    `CHK("untrack", 1'b0, tracking_o);
    $display("done tracking");
    for (int i = 0; i < 19; i++)
    begin
      st = (i < 17) ? 17'h1 << i : 17'h0;
      actual_speed_i = (i == 17) ? 32'hffff_fff0 : 32'h0000_0005;
      alarm_class_i = 2'(i);
      xc();
      `CHK("status1", {~st[14], ~actual_speed_i[31], ~st[13], st[12], ~st[11], st[10:6], ~st[5:4],
        st[3:0]}, main_drive_status_word_o);
      `CHK("status2", {1'b0, st[16], 1'b0, st[15], 1'b0, alarm_class_i, 5'h00},
        second_drive_status_word_o[11:0]);
    end
    $display("done status");
    @(posedge sys_clk_i);
    #1 send = 1'b1;
    repeat (20)
    begin
      @(posedge sys_clk_i);
      #1 chk_life();
    end
    send = 1'b0;
    $display("done sign of life");
    // one skipped step of the controller's count must raise the life fault
    skip = 1'b1;
    xc();
    skip = 1'b0;
    @(posedge sys_clk_i);
    #1 send = 1'b1;
    @(posedge sys_clk_i);
    #1 send = 1'b0;
    `CHK("life_skip", 1'b1, master_life_fault_o);
    `CHK("life_skip_val", nx + 4'h1, master_sign_of_life_o);
    nrst_i = 1'b0;
    nx = 4'h0;
    @(posedge sys_clk_i);
    #1 `CHK("mid_rst", 16'h0000, second_drive_status_word_o);
    `CHK("mid_rst_flt", 1'b0, master_life_fault_o);
    nrst_i = 1'b1;
    xc();
    $display("done fault and reset");
    end_of_test();
  end
endmodule

bind dps_positioning_words dps_pw_checker dps_pw_checker_i (.*);

`default_nettype wire
